// ---- hw/ssu_pkg.sv ----
/*
 * Package for the synchronous serial unit: register offsets, field
 * positions, reset values and the mode enumeration.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
`default_nettype none
package ssu_pkg;
	localparam logic [7:0] SSU_CTRL_OFS   = 8'h00;
	localparam logic [7:0] SSU_STAT_OFS   = 8'h04;
	localparam logic [7:0] SSU_RXDATA_OFS = 8'h08;
	localparam logic [7:0] SSU_TXDATA_OFS = 8'h0C;
	localparam logic [7:0] SSU_IEN_OFS    = 8'h10;
	// Control register fields
	localparam int SSU_C_PORT_EN  = 0;
	localparam int SSU_C_CLOCKED  = 1;
	localparam int SSU_C_HOST     = 2;
	localparam int SSU_C_SINGLE_RECEIVE_ENABLE     = 3;
	localparam int SSU_C_CONTINUOUS_RECEIVE_ENABLE     = 4;
	localparam int SSU_C_TRANSMIT_ENABLE     = 5;
	localparam int SSU_C_RX9      = 6;
	localparam int SSU_C_TX9      = 7;
	localparam int SSU_C_TRANSMIT_NINTH_BIT     = 8;
	localparam int SSU_C_POL      = 9;
	localparam int SSU_C_SLEEP    = 10;
	localparam int SSU_CTRL_W     = 11;
	localparam logic [10:0] SSU_CTRL_RST = 11'h000;
	// Status register fields
	localparam int SSU_S_RECEIVE_NINTH_BIT     = 0;
	localparam int SSU_S_OVERRUN  = 1;
	localparam int SSU_S_RXREADY  = 2;
	localparam int SSU_S_TXFREE   = 3;
	localparam int SSU_S_TSR_EMPTY = 4;
	localparam int SSU_S_COUNT    = 5;
	// Interrupt enable fields
	localparam int SSU_I_RX       = 0;
	localparam int SSU_I_TX       = 1;
	localparam int SSU_I_PERIPH   = 2;
	localparam logic [2:0] SSU_IEN_RST = 3'h0;
	// Host clock half period in pclk cycles
	localparam logic [7:0] SSU_HALF_PERIOD = 8'h04;
	localparam int SSU_FIFO_DEPTH = 2;
	typedef enum logic [1:0] {
		SSU_MODE_OFF,
		SSU_MODE_HOST,
		SSU_MODE_CLIENT
	} ssu_mode_e;
endpackage : ssu_pkg
`default_nettype wire

// ---- hw/ssu_sync3.sv ----
/*
 * Input conditioner for pins from outside the pclk domain.
 * Assumes pclk is much faster than the link clock.
 */
`default_nettype none
module ssu_sync3 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] sh_reg;
	logic [2:0] sh_next;
	logic       out_reg;
	logic       out_next;

	always_comb begin
		sh_next  = {sh_reg[1:0], din};
		out_next = (sh_reg[2] == sh_reg[1]) ? sh_reg[1] : out_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg  <= 3'h0;
			out_reg <= 1'b0;
		end else if (ce) begin
			sh_reg  <= sh_next;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule : ssu_sync3
`default_nettype wire

// ---- hw/ssu_top.sv ----
/*
 * Synchronous (clocked, half-duplex) serial unit with an APB register
 * file. Host mode makes the link clock from pclk; client mode samples
 * the remote link clock through a three-stage conditioner and shifts
 * on its edges. Assumes the link clock is slower than pclk / 6.
 */
`default_nettype none

module ssu_top
	import ssu_pkg::*;
#(
	parameter int DEPTH = SSU_FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        clock_line_in,
	output logic             clock_line_out,
	output logic             clock_line_oe,
	input  wire logic        data_line_in,
	output logic             data_line_out,
	output logic             data_line_oe,
	output logic             wake_request
);
	if (DEPTH != 2) begin : g_bad_depth
		$error("ssu_top: receive FIFO depth must be 2");
	end

	logic [SSU_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [2:0]  ien_reg, ien_next;
	logic [8:0]  fifo_reg [DEPTH];
	logic [8:0]  fifo_next [DEPTH];
	logic [1:0]  cnt_reg, cnt_next;
	logic        ovr_reg, ovr_next;
	logic [8:0]  hold_reg, hold_next;
	logic        hold_full_reg, hold_full_next;
	logic [8:0]  tsr_reg, tsr_next;
	logic        tsr_busy_reg, tsr_busy_next;
	logic [8:0]  rsr_reg, rsr_next;
	logic [3:0]  bit_reg, bit_next;
	logic        txfree_reg, txfree_next;
	logic        ck_reg, ck_next;
	logic        dout_reg, dout_next;
	logic [7:0]  div_reg, div_next;
	logic        lclk_prev_reg;
	logic [31:0] rdata_reg, rdata_next;

	logic      lclk_s, data_s;
	ssu_mode_e mode;
	logic      rx_mode, continuous_receive_enable_eff, lead, trail, nbits9, rx_done;
	logic      wr, rd, fifo_pop, tx_write;
	logic [3:0] nbits;

	ssu_sync3 u_ck (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (clk_en),
		.din     (clock_line_in),
		.dout    (lclk_s)
	);
	ssu_sync3 u_dt (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (clk_en),
		.din     (data_line_in),
		.dout    (data_s)
	);

	function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : sel

	always_comb begin
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		if (!ctrl_reg[SSU_C_PORT_EN] || !ctrl_reg[SSU_C_CLOCKED]) begin
			mode = SSU_MODE_OFF;
		end else if (ctrl_reg[SSU_C_HOST]) begin
			mode = SSU_MODE_HOST;
		end else begin
			mode = SSU_MODE_CLIENT;
		end
		continuous_receive_enable_eff = (mode == SSU_MODE_CLIENT) ? ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE]
			: ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE] || ctrl_reg[SSU_C_SINGLE_RECEIVE_ENABLE];
		rx_mode = ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE] || ctrl_reg[SSU_C_SINGLE_RECEIVE_ENABLE];
		nbits9 = rx_mode ? ctrl_reg[SSU_C_RX9] : ctrl_reg[SSU_C_TX9];
		nbits = nbits9 ? 4'h9 : 4'h8;
		// Leading/trailing edges; selects which pin edge leads
		if (mode == SSU_MODE_CLIENT) begin
			lead  = (lclk_s != lclk_prev_reg)
				&& (lclk_s != ctrl_reg[SSU_C_POL]);
			trail = (lclk_s != lclk_prev_reg)
				&& (lclk_s == ctrl_reg[SSU_C_POL]);
		end else if (mode == SSU_MODE_HOST && div_reg == 8'h00
			&& !ctrl_reg[SSU_C_SLEEP]) begin
			lead  = (ck_reg == ctrl_reg[SSU_C_POL]);
			trail = (ck_reg != ctrl_reg[SSU_C_POL]);
		end else begin
			lead  = 1'b0;
			trail = 1'b0;
		end
		fifo_pop = rd && sel(paddr, SSU_RXDATA_OFS) && cnt_reg != 2'h0;
		tx_write = wr && sel(paddr, SSU_TXDATA_OFS);
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		ien_next = ien_reg;
		fifo_next = fifo_reg;
		cnt_next = cnt_reg;
		ovr_next = ovr_reg;
		hold_next = hold_reg;
		hold_full_next = hold_full_reg;
		tsr_next = tsr_reg;
		tsr_busy_next = tsr_busy_reg;
		rsr_next = rsr_reg;
		bit_next = bit_reg;
		txfree_next = txfree_reg;
		ck_next = ck_reg;
		dout_next = dout_reg;
		div_next = div_reg;
		rx_done = 1'b0;

		if (wr && sel(paddr, SSU_CTRL_OFS)) begin
			ctrl_next = pwdata[SSU_CTRL_W-1:0];
		end
		if (wr && sel(paddr, SSU_IEN_OFS)) begin
			ien_next = pwdata[2:0];
		end
		if (fifo_pop) begin
			fifo_next[0] = fifo_reg[1];
			cnt_next = cnt_reg - 2'h1;
			if (!ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE]) begin
				ovr_next = 1'b0;
			end
		end
		if (tx_write) begin
			hold_next = {ctrl_reg[SSU_C_TRANSMIT_NINTH_BIT], pwdata[7:0]};
			hold_full_next = 1'b1;
			txfree_next = 1'b0;
		end
		// Host clock divider
		if (mode == SSU_MODE_HOST) begin
			div_next = (div_reg == 8'h00) ? SSU_HALF_PERIOD - 8'h01
				: div_reg - 8'h01;
		end

		if (rx_mode && mode != SSU_MODE_OFF) begin
			if (mode == SSU_MODE_HOST && (!continuous_receive_enable_eff || ovr_reg)) begin
				ck_next = ctrl_reg[SSU_C_POL];
			end else if (!ovr_reg && continuous_receive_enable_eff && (lead || trail)) begin
				if (mode == SSU_MODE_HOST) begin
					ck_next = !ck_reg;
				end
				if (trail) begin
					rsr_next = {data_s, rsr_reg[8:1]};
					if (bit_reg == nbits - 4'h1) begin
						rx_done = 1'b1;
						bit_next = 4'h0;
						rsr_next = nbits9 ? {data_s, rsr_reg[8:1]}
							: {1'b0, data_s, rsr_reg[8:2]};
					end else begin
						bit_next = bit_reg + 4'h1;
					end
				end
			end
			if (rx_done) begin
				if (cnt_next == 2'h2) begin
					ovr_next = 1'b1;
				end else begin
					fifo_next[cnt_next[0]] = rsr_next;
					cnt_next = cnt_next + 2'h1;
				end
				if (!ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE] && mode == SSU_MODE_HOST) begin
					ctrl_next[SSU_C_SINGLE_RECEIVE_ENABLE] = 1'b0;
				end
			end
		end else if (mode != SSU_MODE_OFF && ctrl_reg[SSU_C_TRANSMIT_ENABLE]) begin
			if (!tsr_busy_reg && hold_full_reg) begin
				tsr_next = hold_reg;
				tsr_busy_next = 1'b1;
				// A write in the same cycle keeps the new byte pending
				hold_full_next = tx_write;
				txfree_next = !tx_write;
				bit_next = 4'h0;
			end else if (tsr_busy_reg && (lead || trail)) begin
				if (mode == SSU_MODE_HOST) begin
					ck_next = !ck_reg;
				end
				if (lead) begin
					dout_next = tsr_reg[0];
				end else begin
					tsr_next = {1'b0, tsr_reg[8:1]};
					if (bit_reg == nbits - 4'h1) begin
						tsr_busy_next = 1'b0;
						bit_next = 4'h0;
					end else begin
						bit_next = bit_reg + 4'h1;
					end
				end
			end
		end else begin
			ck_next = ctrl_reg[SSU_C_POL];
			bit_next = 4'h0;
		end

		// clearing continuous receive or port enable ends overrun
		if (!ctrl_reg[SSU_C_PORT_EN]) begin
			ovr_next = 1'b0;
			cnt_next = 2'h0;
			hold_full_next = 1'b0;
			tsr_busy_next = 1'b0;
			txfree_next = 1'b1;
			bit_next = 4'h0;
			ctrl_next[SSU_C_SINGLE_RECEIVE_ENABLE] = ctrl_next[SSU_C_SINGLE_RECEIVE_ENABLE] && wr;
		end else if (ovr_reg && ctrl_reg[SSU_C_CONTINUOUS_RECEIVE_ENABLE]
			&& !ctrl_next[SSU_C_CONTINUOUS_RECEIVE_ENABLE]) begin
			ovr_next = 1'b0;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (sel(paddr, SSU_CTRL_OFS)) begin
			rdata_next[SSU_CTRL_W-1:0] = ctrl_reg;
		end else if (sel(paddr, SSU_STAT_OFS)) begin
			rdata_next[SSU_S_RECEIVE_NINTH_BIT] = fifo_reg[0][8];
			rdata_next[SSU_S_OVERRUN] = ovr_reg;
			rdata_next[SSU_S_RXREADY] = cnt_reg != 2'h0;
			rdata_next[SSU_S_TXFREE] = txfree_reg;
			rdata_next[SSU_S_TSR_EMPTY] = !tsr_busy_reg;
			rdata_next[SSU_S_COUNT+1:SSU_S_COUNT] = cnt_reg;
		end else if (sel(paddr, SSU_RXDATA_OFS)) begin
			rdata_next[7:0] = fifo_reg[0][7:0];
		end else if (sel(paddr, SSU_IEN_OFS)) begin
			rdata_next[2:0] = ien_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= SSU_CTRL_RST;
			ien_reg <= SSU_IEN_RST;
			for (int i = 0; i < DEPTH; i++) begin
				fifo_reg[i] <= 9'h000;
			end
			cnt_reg <= 2'h0;
			ovr_reg <= 1'b0;
			hold_reg <= 9'h000;
			hold_full_reg <= 1'b0;
			tsr_reg <= 9'h000;
			tsr_busy_reg <= 1'b0;
			rsr_reg <= 9'h000;
			bit_reg <= 4'h0;
			txfree_reg <= 1'b1;
			ck_reg <= 1'b0;
			dout_reg <= 1'b0;
			div_reg <= 8'h00;
			lclk_prev_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			ien_reg <= ien_next;
			fifo_reg <= fifo_next;
			cnt_reg <= cnt_next;
			ovr_reg <= ovr_next;
			hold_reg <= hold_next;
			hold_full_reg <= hold_full_next;
			tsr_reg <= tsr_next;
			tsr_busy_reg <= tsr_busy_next;
			rsr_reg <= rsr_next;
			bit_reg <= bit_next;
			txfree_reg <= txfree_next;
			ck_reg <= ck_next;
			dout_reg <= dout_next;
			div_reg <= div_next;
			lclk_prev_reg <= lclk_s;
			rdata_reg <= rdata_next;
		end
	end

	always_comb begin
		prdata = rdata_reg;
		pready = 1'b1;
		pslverr = psel && penable && !(sel(paddr, SSU_CTRL_OFS)
			|| sel(paddr, SSU_STAT_OFS) || sel(paddr, SSU_RXDATA_OFS)
			|| sel(paddr, SSU_TXDATA_OFS) || sel(paddr, SSU_IEN_OFS));
		clock_line_out = ck_reg;
		clock_line_oe = mode == SSU_MODE_HOST;
		data_line_out = dout_reg;
		data_line_oe = mode != SSU_MODE_OFF && !rx_mode
			&& ctrl_reg[SSU_C_TRANSMIT_ENABLE];
		wake_request = (ien_reg[SSU_I_RX] && cnt_reg != 2'h0)
			|| (ien_reg[SSU_I_TX] && ien_reg[SSU_I_PERIPH] && txfree_reg);
	end
endmodule : ssu_top
`default_nettype wire

// ---- sim/ssu_checker.sv ----
/* Port checker for ssu_top: direction, host clock and bus answers.
   Assumes a bind onto ssu_top and a single pclk domain. */
`default_nettype none
module ssu_checker
	import ssu_pkg::*;
#(
	parameter int DEPTH = SSU_FIFO_DEPTH
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        clock_line_in,
	input wire logic        clock_line_out,
	input wire logic        clock_line_oe,
	input wire logic        data_line_in,
	input wire logic        data_line_out,
	input wire logic        data_line_oe,
	input wire logic        wake_request
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic wr_ctrl;
	logic unmap;
	logic tx_set;
	assign acc = psel && penable && clk_en;
	assign wr_ctrl = acc && pwrite && paddr == SSU_CTRL_OFS;
	assign unmap = !(paddr inside {SSU_CTRL_OFS, SSU_STAT_OFS,
		SSU_RXDATA_OFS, SSU_TXDATA_OFS, SSU_IEN_OFS});
	assign tx_set = wr_ctrl && pwdata[SSU_C_PORT_EN]
		&& pwdata[SSU_C_CLOCKED] && pwdata[SSU_C_TRANSMIT_ENABLE]
		&& !pwdata[SSU_C_SINGLE_RECEIVE_ENABLE] && !pwdata[SSU_C_CONTINUOUS_RECEIVE_ENABLE];
	port_off_a: assert property (
		wr_ctrl && !pwdata[SSU_C_PORT_EN]
		|-> ##[1:2] !clock_line_oe && !data_line_oe)
		else $error("port off left a driver on");
	client_clock_a: assert property (
		wr_ctrl && !pwdata[SSU_C_HOST] |-> ##[1:2] !clock_line_oe)
		else $error("client drives the link clock");
	host_clock_a: assert property (
		wr_ctrl && pwdata[SSU_C_PORT_EN] && pwdata[SSU_C_CLOCKED]
		&& pwdata[SSU_C_HOST] |-> ##[1:2] clock_line_oe)
		else $error("host does not drive the link clock");
	tx_dir_a: assert property (tx_set |-> ##[1:2] data_line_oe)
		else $error("transmit mode not driving data");
	rx_dir_a: assert property (
		wr_ctrl && pwdata[SSU_C_CONTINUOUS_RECEIVE_ENABLE] |-> ##[1:2] !data_line_oe)
		else $error("receive mode drives data");
	clk_high_a: assert property (
		$rose(clock_line_out) && clock_line_oe |-> clock_line_out[*4])
		else $error("host clock high phase short");
	clk_low_a: assert property (
		$fell(clock_line_out) && clock_line_oe |-> !clock_line_out[*4])
		else $error("host clock low phase short");
	refuse_a: assert property (pslverr == (psel && penable && unmap)
		&& (!(acc && !pwrite && unmap) || prdata == 32'h0000_0000))
		else $error("unmapped access answer wrong");
	cover property ($rose(clock_line_oe));
	cover property ($rose(wake_request));
	cover property (pslverr);
endmodule : ssu_checker
bind ssu_top ssu_checker #(.DEPTH(DEPTH)) u_chk (.pclk(pclk),
	.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .clock_line_in(clock_line_in),
	.clock_line_out(clock_line_out), .clock_line_oe(clock_line_oe),
	.data_line_in(data_line_in), .data_line_out(data_line_out),
	.data_line_oe(data_line_oe), .wake_request(wake_request));
`default_nettype wire

// ---- sim/ssu_host_model.sv ----
/* Remote link host: clocks frames of bits, LSB first, clock idle low.
   Assumes the client needs a 400 ns link period. */
`default_nettype none
module ssu_host_model (
	output logic      clk_o,
	output logic      dat_o,
	input  wire logic dat_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		clk_o = 1'b0;
		dat_o = 1'b0;
	end
	task automatic send(input logic [8:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			dat_o = w[i];
			#100 clk_o = 1'b1;
			#200 clk_o = 1'b0;
			#100;
		end
		// Released line shows the inverse
		dat_o = ~dat_o;
	endtask : send
	task automatic recv(output logic [7:0] w);
		for (int i = 0; i < 8; i++) begin
			#100 clk_o = 1'b1;
			#200 clk_o = 1'b0;
			#90 w[i] = dat_i;
			#10;
		end
	endtask : recv
endmodule : ssu_host_model
`default_nettype wire

// ---- sim/ssu_top_tb.sv ----
/* Self-checking bench for ssu_top over APB with a link host model.
   Assumes a 20 MHz pclk and zero-wait APB answers. */
`default_nettype none
module ssu_top_tb
	import ssu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready, pslverr, ck_out, ck_oe, dt_out, dt_oe, wake;
	logic        m_ck, m_dt, ck_w, dt_w;
	logic [7:0]  b;
	int          errors = 0;
	int          cmp_count = 0;
	int          edges = 0;
	always #25 pclk = ~pclk;
	assign ck_w = ck_oe ? ck_out : m_ck;
	assign dt_w = dt_oe ? dt_out : m_dt;
	always @(posedge ck_out) edges++;
	ssu_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_line_in(ck_w), .clock_line_out(ck_out),
		.clock_line_oe(ck_oe), .data_line_in(dt_w),
		.data_line_out(dt_out), .data_line_oe(dt_oe),
		.wake_request(wake));
	ssu_host_model m (.clk_o(m_ck), .dat_o(m_dt), .dat_i(dt_w));
	task automatic conclude();
		$display("errors %0d cmp_count %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int   n;
		logic rdy;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer and read data taken at the edge where pready is seen
		do begin
			@(posedge pclk);
			q   = prdata;
			rdy = pready;
			n++;
		end while (rdy !== 1'b1 && n < 50);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			errors++;
			conclude();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] mk,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q & mk, e);
	endtask : rd
	task automatic poll(input logic [7:0] a, input logic [31:0] mk,
		input logic [31:0] e);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((q & mk) !== e && n < 400);
		check(q & mk, e);
		if (n >= 400) begin
			conclude();
		end
	endtask : poll
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(SSU_CTRL_OFS, 32'hFFFF_FFFF, 32'h0);
		rd(SSU_STAT_OFS, 32'hFFFF_FFFF, 32'h18);
		rd(SSU_IEN_OFS, 32'hFFFF_FFFF, 32'h0);
		rd(8'h14, 32'hFFFF_FFFF, 32'h0);
		apb(1'b1, SSU_IEN_OFS, 32'h1);
		apb(1'b1, SSU_CTRL_OFS, 32'h453);
		check(32'(wake), 32'h0);
		m.send(9'h1A5, 9);
		poll(SSU_STAT_OFS, 32'h4, 32'h4);
		check(32'(wake), 32'h1);
		m.send(9'h05A, 9);
		m.send(9'h1FF, 9);
		poll(SSU_STAT_OFS, 32'h7F, 32'h5F);
		rd(SSU_RXDATA_OFS, 32'hFF, 32'hA5);
		rd(SSU_STAT_OFS, 32'h63, 32'h22);
		rd(SSU_RXDATA_OFS, 32'hFF, 32'h5A);
		apb(1'b1, SSU_CTRL_OFS, 32'h443);
		rd(SSU_STAT_OFS, 32'h2, 32'h0);
		apb(1'b1, SSU_CTRL_OFS, 32'h0);
		apb(1'b1, SSU_CTRL_OFS, 32'h0B);
		m.send(9'h0C3, 8);
		repeat (20) @(posedge pclk);
		rd(SSU_STAT_OFS, 32'h4, 32'h0);
		apb(1'b1, SSU_CTRL_OFS, 32'h0);
		edges = 0;
		apb(1'b1, SSU_CTRL_OFS, 32'h0F);
		poll(SSU_CTRL_OFS, 32'h7FF, 32'h7);
		check(edges, 32'h8);
		rd(SSU_STAT_OFS, 32'h64, 32'h24);
		apb(1'b1, SSU_CTRL_OFS, 32'h0);
		apb(1'b1, SSU_IEN_OFS, 32'h6);
		apb(1'b1, SSU_CTRL_OFS, 32'h423);
		apb(1'b1, SSU_TXDATA_OFS, 32'h3C);
		apb(1'b1, SSU_TXDATA_OFS, 32'hC3);
		rd(SSU_STAT_OFS, 32'h18, 32'h0);
		check(32'(wake), 32'h0);
		m.recv(b);
		check({24'h0, b}, 32'h3C);
		poll(SSU_STAT_OFS, 32'h8, 32'h8);
		check(32'(wake), 32'h1);
		m.recv(b);
		check({24'h0, b}, 32'hC3);
		conclude();
	end
endmodule : ssu_top_tb
`default_nettype wire
